// file: rtl/serial_seq_pkg.sv
// package for the serial unit enable sequencing block
// assumes a single 100 MHz clock domain; no register bus, bits are plain ports
package serial_seq_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DATA_BITS = 8;
  localparam int RATE_DIV_W = 8;
  localparam int BIT_COUNT_W = 4;
  localparam logic [RATE_DIV_W-1:0] RATE_DIV_RESET = 8'h00;
  localparam logic [BIT_COUNT_W-1:0] BIT_COUNT_ZERO = 4'h0;
  localparam logic [BIT_COUNT_W-1:0] BIT_COUNT_LAST = 4'h9; // start + 8 data + stop
  localparam logic [DATA_BITS-1:0] DATA_ZERO = 8'h00;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
  localparam logic [3:0] OVERSAMPLE_ZERO = 4'h0;
  localparam logic [1:0] SYNC_STAGES_RESET = 2'h0;
  localparam logic LINE_IDLE = 1'b1;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} rx_state_t;
endpackage

// file: rtl/enable_sync_if.sv
// interface carrying the synchronised enables between top and synchroniser
// assumes the base-clock tick is a one-cycle pulse in clock_i domain
`timescale 1ns/1ps
interface enable_sync_if;
  logic tick;
  logic enable_raw;
  logic enable_synced;
  modport sync_side (input tick, input enable_raw, output enable_synced);
  modport user_side (output tick, output enable_raw, input enable_synced);
endinterface

// file: rtl/base_clock_sync.sv
// two-stage synchroniser of an enable bit, stepped by the base-clock tick
// assumes tick pulses once per base-clock period
`timescale 1ns/1ps
module base_clock_sync (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic power_i,
  // enable path
  enable_sync_if.sync_side port_s
);
  import serial_seq_pkg::*;
  logic [1:0] stages;
  // enable advances one stage per base clock; power off clears it
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stages <= SYNC_STAGES_RESET;
    end else if (!power_i) begin
      stages <= SYNC_STAGES_RESET;
    end else if (port_s.tick) begin
      stages <= {stages[0], port_s.enable_raw};
    end
  end
  assign port_s.enable_synced = stages[1];
endmodule // base_clock_sync

// file: rtl/serial_enable_unit.sv
// serial unit with power and enable sequencing, transmitter and receiver
// assumes the unit clock is gated outside when stopped; software keeps ordering
`timescale 1ns/1ps
module serial_enable_unit #(
  parameter int DIV_W = serial_seq_pkg::RATE_DIV_W
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // control bits
  input wire logic unit_power_bit_i,
  input wire logic transmit_enable_bit_i,
  input wire logic receive_enable_bit_i,
  input wire logic [DIV_W-1:0] rate_generator_control_i,
  // transmit data
  input wire logic [serial_seq_pkg::DATA_BITS-1:0] tx_data_i,
  input wire logic tx_load_i,
  // serial line
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  // status
  output logic tx_busy_o,
  output logic tx_enabled_o,
  output logic rx_enabled_o,
  output logic [serial_seq_pkg::DATA_BITS-1:0] rx_data_o,
  output logic rx_valid_o
);
  import serial_seq_pkg::*;

  // divider and oversampling counters
  logic [DIV_W-1:0] div_count;
  logic base_tick;
  logic [3:0] tx_phase;
  logic [3:0] rx_phase;
  logic [BIT_COUNT_W-1:0] tx_bits;
  logic [BIT_COUNT_W-1:0] rx_bits;

  // frame shifters and state
  logic [DATA_BITS:0] tx_shift;
  logic [DATA_BITS-1:0] rx_shift;
  tx_state_t tx_state;
  rx_state_t rx_state;

  // synchronised enables and the carriers that bring them back
  logic tx_en;
  logic rx_en;
  enable_sync_if tx_if ();
  enable_sync_if rx_if ();

  // base clock: one tick per rate_generator_control+1 cycles; registers only
  // move on clock_i edges and the asynchronous reset, so a stopped clock freezes all of them out of reset
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_count <= DIV_W'(RATE_DIV_RESET);
      base_tick <= 1'b0;
    end else if (!unit_power_bit_i) begin
      div_count <= DIV_W'(RATE_DIV_RESET);
      base_tick <= 1'b0;
    end else if (div_count >= rate_generator_control_i) begin
      div_count <= DIV_W'(RATE_DIV_RESET);
      base_tick <= 1'b1;
    end else begin
      div_count <= div_count + DIV_W'(1);
      base_tick <= 1'b0;
    end
  end

  // both synchronisers step on the one shared base tick
  assign tx_if.tick = base_tick;
  assign tx_if.enable_raw = transmit_enable_bit_i;
  assign rx_if.tick = base_tick;
  assign rx_if.enable_raw = receive_enable_bit_i;

  // synchronised enables as the transmit and receive circuits see them
  assign tx_en = tx_if.enable_synced;
  assign rx_en = rx_if.enable_synced;

  // enables pass two base-clock stages; a clear shorter than that may be missed,
  // which is why software must hold it low two base clocks
  base_clock_sync tx_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .power_i(unit_power_bit_i),
    .port_s(tx_if.sync_side)
  );
  base_clock_sync rx_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .power_i(unit_power_bit_i),
    .port_s(rx_if.sync_side)
  );

  // transmitter: 16 ticks per bit, lsb first, one start and one stop bit
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_state <= TX_IDLE;
      tx_phase <= OVERSAMPLE_ZERO;
      tx_bits <= BIT_COUNT_ZERO;
      tx_shift <= {DATA_ZERO, LINE_IDLE};
      serial_out_pin_o <= LINE_IDLE;
    end else if (!unit_power_bit_i || !tx_en) begin
      tx_state <= TX_IDLE;
      tx_phase <= OVERSAMPLE_ZERO;
      tx_bits <= BIT_COUNT_ZERO;
      tx_shift <= {DATA_ZERO, LINE_IDLE}; // no stale bits survive into the next frame
      serial_out_pin_o <= LINE_IDLE;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_load_i) begin
            tx_shift <= {LINE_IDLE, tx_data_i};
            serial_out_pin_o <= 1'b0; // start bit
            tx_phase <= OVERSAMPLE_ZERO;
            tx_bits <= BIT_COUNT_ZERO;
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (base_tick) begin
            tx_phase <= tx_phase + 4'h1;
            if (tx_phase == OVERSAMPLE_LAST) begin
              if (tx_bits == BIT_COUNT_LAST) begin
                tx_state <= TX_IDLE;
                serial_out_pin_o <= LINE_IDLE;
              end else begin
                serial_out_pin_o <= tx_shift[0]; // held while clock is stopped
                tx_shift <= {LINE_IDLE, tx_shift[DATA_BITS:1]};
                tx_bits <= tx_bits + 4'h1;
              end
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // receiver: a low line once enabled starts a frame immediately, even if it
  // was already low at enable time; software should enable on a high line
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_state <= RX_IDLE;
      rx_phase <= OVERSAMPLE_ZERO;
      rx_bits <= BIT_COUNT_ZERO;
      rx_shift <= DATA_ZERO;
      rx_data_o <= DATA_ZERO;
      rx_valid_o <= 1'b0;
    end else if (!unit_power_bit_i || !rx_en) begin
      rx_state <= RX_IDLE;
      rx_phase <= OVERSAMPLE_ZERO;
      rx_bits <= BIT_COUNT_ZERO;
      rx_shift <= DATA_ZERO; // a frame after disable or power off starts from an empty shifter
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (!serial_in_pin_i) begin
            rx_state <= RX_SHIFT;
            rx_phase <= OVERSAMPLE_ZERO;
            rx_bits <= BIT_COUNT_ZERO;
          end
        end
        RX_SHIFT: begin
          if (base_tick) begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase == OVERSAMPLE_MID) begin
              if (rx_bits == BIT_COUNT_LAST) begin
                rx_state <= RX_IDLE;
                rx_data_o <= rx_shift;
                rx_valid_o <= serial_in_pin_i; // only on a good stop bit
              end else begin
                if (rx_bits != BIT_COUNT_ZERO) begin
                  rx_shift <= {serial_in_pin_i, rx_shift[DATA_BITS-1:1]};
                end
                rx_bits <= rx_bits + 4'h1;
              end
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // busy follows the transmit state one cycle late, straight from a flip-flop
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_busy_o <= 1'b0;
    end else begin
      tx_busy_o <= (tx_state == TX_SHIFT);
    end
  end

  // transmit enable as the circuit sees it, one cycle behind the synchroniser
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_enabled_o <= 1'b0;
    end else begin
      tx_enabled_o <= tx_en;
    end
  end

  // receive enable likewise; software polls it before trusting the receiver
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_enabled_o <= 1'b0;
    end else begin
      rx_enabled_o <= rx_en;
    end
  end
endmodule // serial_enable_unit

// file: bench/serial_enable_unit_properties.sv
// checker for the enable sequencing block, bound to its top module
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
module serial_enable_unit_properties #(parameter int DIV_W = 8) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // control bits
  input wire logic unit_power_bit_i,
  input wire logic transmit_enable_bit_i,
  input wire logic receive_enable_bit_i,
  input wire logic [DIV_W-1:0] rate_generator_control_i,
  // transmit data
  input wire logic [7:0] tx_data_i,
  input wire logic tx_load_i,
  // serial line
  input wire logic serial_in_pin_i,
  input wire logic serial_out_pin_o,
  // status
  input wire logic tx_busy_o,
  input wire logic tx_enabled_o,
  input wire logic rx_enabled_o,
  input wire logic [7:0] rx_data_o,
  input wire logic rx_valid_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // three cycles give the cleared synchronisers time to reach the copies
  sequence off_s; !unit_power_bit_i [*3]; endsequence
  a_off_enables: assert property (off_s |-> !tx_enabled_o && !rx_enabled_o)
    else $error("enable seen while unit power is off");
  a_off_line: assert property (off_s |-> serial_out_pin_o && !tx_busy_o && !rx_valid_o)
    else $error("serial activity while unit power is off");
  a_tx_sync: assert property ($rose(transmit_enable_bit_i) && !tx_enabled_o |=> !tx_enabled_o)
    else $error("transmit enable passed without base clock sync");
  a_rx_sync: assert property ($rose(receive_enable_bit_i) && !rx_enabled_o |=> !rx_enabled_o)
    else $error("receive enable passed without base clock sync");
  // worst case is two ticks at the slowest divider plus the copy stages
  a_tx_arrive: assert property ($rose(transmit_enable_bit_i) |-> ##[1:520]
    (tx_enabled_o || !unit_power_bit_i || !transmit_enable_bit_i))
    else $error("transmit enable never arrived");
  a_rx_arrive: assert property ($rose(receive_enable_bit_i) |-> ##[1:520]
    (rx_enabled_o || !unit_power_bit_i || !receive_enable_bit_i))
    else $error("receive enable never arrived");
  a_tx_start: assert property ($rose(tx_busy_o) |-> !serial_out_pin_o && $past(tx_enabled_o))
    else $error("frame began without start bit or enable");
  a_line_idle: assert property (!tx_busy_o && !$past(tx_load_i) |-> serial_out_pin_o)
    else $error("serial output low while transmitter idle");
  a_rx_pulse: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("receive valid longer than one cycle");
endmodule // serial_enable_unit_properties
bind serial_enable_unit serial_enable_unit_properties #(.DIV_W(DIV_W))
  serial_enable_unit_properties_inst (.clock_i, .resetn_i, .unit_power_bit_i,
  .transmit_enable_bit_i, .receive_enable_bit_i, .tx_load_i, .serial_in_pin_i,
  .serial_out_pin_o, .tx_busy_o, .tx_enabled_o, .rx_enabled_o, .rx_valid_o,
  .rate_generator_control_i, .tx_data_i, .rx_data_o);

// file: bench/serial_partner.sv
// remote serial transceiver model for the bench
// assumes 8 data bits lsb first, one stop bit, bit time given in clocks
`timescale 1ns/1ps
module serial_partner #(parameter int BIT_CLK = 32) (
  input wire logic clock_i,
  input wire logic line_i,
  output logic line_o
);
  // idle high so enabling reception never starts a false frame
  initial line_o = 1'b1;
  // frame out: start, data, stop; called just after a clock edge
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o = f[i];
      repeat (BIT_CLK) @(posedge clock_i);
      #1;
    end
  endtask
  // frame in: each data bit sampled at its middle
  task automatic recv(output logic [7:0] b);
    @(negedge line_i);
    repeat (BIT_CLK / 2) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLK) @(posedge clock_i);
      #1;
      b[i] = line_i;
    end
  endtask
endmodule // serial_partner

// file: bench/test_uart_enable_sequencing.sv
// testbench for the enable sequencing block with a remote transceiver
// assumes divider setting 1 for frames (a bit is 32 clocks); a slower one for timing only
`timescale 1ns/1ps
module test_uart_enable_sequencing;
  logic clock_i = 1'b0, resetn_i = 1'b0, run = 1'b1, pw = 1'b0, te = 1'b0, re = 1'b0;
  logic ld = 1'b0, sin, sout, busy, ten, ren, rv;
  logic [7:0] txd = 8'h00, rxd;
  logic [7:0] rate = 8'h01;
  int fails = 0, comparisons = 0, nvalid = 0, cycles = 0;
  serial_enable_unit serial_enable_unit_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .unit_power_bit_i(pw), .transmit_enable_bit_i(te), .receive_enable_bit_i(re),
    .rate_generator_control_i(rate), .tx_data_i(txd), .tx_load_i(ld),
    .serial_in_pin_i(sin), .serial_out_pin_o(sout), .tx_busy_o(busy),
    .tx_enabled_o(ten), .rx_enabled_o(ren), .rx_data_o(rxd), .rx_valid_o(rv));
  serial_partner #(.BIT_CLK(32)) serial_partner_inst (.clock_i(clock_i), .line_i(sout),
    .line_o(sin));
  // run can stop the clock to model the unit losing its clock supply
  always #5 if (run) clock_i = ~clock_i;
  // counts valid pulses and cuts a hang short
  always @(posedge clock_i) begin
    nvalid += (rv === 1'b1);
    cycles++;
    if (cycles == 6000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic t_up;
    pw = 1'b1;
    tick(1);
    te = 1'b1;
    re = 1'b1;
    tick(1);
    chk("tx enabled early", 8'h00, ten);
    tick(12);
    chk("tx enabled", 8'h01, ten);
    chk("rx enabled", 8'h01, ren);
  endtask
  // both directions at once
  task automatic t_loop(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] got;
    int n0;
    n0 = nvalid;
    fork
      serial_partner_inst.send(a);
      serial_partner_inst.recv(got);
      begin txd = b; ld = 1'b1; tick(1); ld = 1'b0; end
    join
    chk("received byte", a, rxd);
    chk("valid pulses", 8'(n0 + 1), 8'(nvalid));
    chk("sent byte", b, got);
    tick(40);
  endtask
  // re-enable after a three-tick gap, then a frame must still work
  task automatic t_reenable;
    te = 1'b0;
    tick(6);
    chk("tx disabled", 8'h00, ten);
    te = 1'b1;
    tick(12);
    t_loop(8'h5A, 8'hC3);
  endtask
  // enabling while the line is already low starts reception at once
  task automatic t_rx_low;
    re = 1'b0;
    tick(6);
    fork
      serial_partner_inst.send(8'h96);
      begin tick(2); re = 1'b1; end
    join
    chk("low-start byte", 8'h96, rxd);
    tick(10);
  endtask
  // clock stops mid start bit; then software reset and refused load
  task automatic t_stop;
    txd = 8'hFF;
    ld = 1'b1;
    tick(1);
    ld = 1'b0;
    tick(20);
    run = 1'b0;
    #200;
    chk("held line", 8'h00, sout);
    chk("held busy", 8'h01, busy);
    run = 1'b1;
    te = 1'b0;
    re = 1'b0;
    tick(1);
    pw = 1'b0;
    ld = 1'b1;
    tick(4);
    ld = 1'b0;
    chk("line off", 8'h01, sout);
    chk("busy off", 8'h00, busy);
    chk("tx off", 8'h00, ten);
  endtask
  // slower base clock: the enables must wait for two of its longer ticks
  task automatic t_slow;
    te = 1'b0;
    re = 1'b0;
    tick(1);
    pw = 1'b0;
    rate = 8'h03;
    tick(8);
    pw = 1'b1;
    tick(1);
    te = 1'b1;
    re = 1'b1;
    tick(6);
    chk("slow tx early", 8'h00, ten);
    tick(8);
    chk("slow tx enabled", 8'h01, ten);
    chk("slow rx enabled", 8'h01, ren);
  endtask
  task automatic print_verdict;
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    tick(12);
    resetn_i = 1'b1;
    t_up();
    t_loop(8'hA5, 8'h3C);
    t_reenable();
    t_rx_low();
    t_stop();
    t_up();
    t_loop(8'h01, 8'h80);
    t_slow();
    print_verdict();
  end
endmodule // test_uart_enable_sequencing
